// ==== hdl/bridge_strap_and_gpio_config.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: wake pin pulled low when power needed
// R2: eight pins, each own direction bit
// R3: clock-stop strap 0 off, 1 on
// R4: arbiter strap 0 internal, 1 outside
// R5: pin0 direction bit0, clock-stop input mode
// R6: pin1 is override output on 001b/011b
// R7: compat mode when pin2 high at release
// R8: pins 4/5 serial bus if data pulled up
// R9: pins 3,6,7 use direction bits 3,6,7
// R10: global reset clears all logic
// R11: lock pin active only when bit 12 set
// R12: speed strap 0 gives 33, 1 gives 66 MHz
// R13: ref strap 0 100 MHz diff, 1 125 MHz
// R14: serial irq enabled if pulled up at release
// R15: single-lane 2.5 Gb/s link to upstream
// R16: upstream drives link reset input
// R17: straps latched until next reset
module bridge_strap_and_gpio_config (
  input wire logic clock,
  input wire logic reset,
  input wire logic global_async_reset,
  input wire logic link_reset_n, // R16
  // strap pins
  input wire logic clock_stop_feature_strap,
  input wire logic outside_arbiter_strap,
  input wire logic bus_speed_strap,
  input wire logic ref_clock_source_strap,
  input wire logic serial_interrupt_pin,
  // general-purpose pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  // internal functions on shared pins
  input wire logic wake_request,
  input wire logic power_override_value,
  output logic clock_stop_request_pin,
  output logic lock_mode,
  output logic serial_bus_mode,
  output logic power_override_output,
  output logic wake_oe,
  output strap_cfg_pkg::straps_s straps,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // global reset acts at once; link-reset release only resamples straps

  logic [7:0] gpio_ctrl_ff, nxt_gpio_ctrl;
  logic [7:0] gpio_out_ff, nxt_gpio_out;
  logic [31:0] gen_ctrl_ff, nxt_gen_ctrl;
  logic wake_sw_ff, nxt_wake_sw;
  logic [7:0] aw_addr_ff, nxt_aw_addr;
  logic aw_have_ff, nxt_aw_have;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic w_have_ff, nxt_w_have;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  strap_cfg_pkg::straps_s straps_ff, nxt_straps;
  logic link_rst_d_ff;
  logic sampled_ff, nxt_sampled;
  logic [7:0] pin_out_ff, nxt_pin_out;
  logic [7:0] pin_oe_ff, nxt_pin_oe;
  logic [7:0] pin_in_ff;
  logic wake_oe_ff, nxt_wake_oe;
  logic clk_stop_ff, lock_ff, ovrd_out_ff;
  logic nxt_clk_stop, nxt_lock, nxt_ovrd_out;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // write channel: address and data accepted in either order
  logic do_write;
  logic [31:0] wr_word;
  always_comb begin
    nxt_aw_addr = aw_addr_ff;
    nxt_aw_have = aw_have_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_w_have = w_have_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_gpio_ctrl = gpio_ctrl_ff;
    nxt_gpio_out = gpio_out_ff;
    nxt_gen_ctrl = gen_ctrl_ff;
    nxt_wake_sw = wake_sw_ff;
    wr_word = 32'h0000_0000;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_addr = s_axi_awaddr;
      nxt_aw_have = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
      nxt_w_have = 1'b1;
    end
    do_write = aw_have_ff && w_have_ff && !bvalid_ff;
    if (do_write) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = strap_cfg_pkg::RESP_OKAY;
      unique case (aw_addr_ff)
        strap_cfg_pkg::GPIO_CTRL_ADDR: begin
          wr_word = merge({24'h000000, gpio_ctrl_ff}, w_data_ff, w_strb_ff);
          nxt_gpio_ctrl = wr_word[7:0]; // R2
        end
        strap_cfg_pkg::GPIO_OUT_ADDR: begin
          wr_word = merge({24'h000000, gpio_out_ff}, w_data_ff, w_strb_ff);
          nxt_gpio_out = wr_word[7:0];
        end
        strap_cfg_pkg::GEN_CTRL_ADDR: begin
          nxt_gen_ctrl = merge(gen_ctrl_ff, w_data_ff, w_strb_ff);
        end
        strap_cfg_pkg::WAKE_ADDR: begin
          wr_word = merge({31'h00000000, wake_sw_ff}, w_data_ff, w_strb_ff);
          nxt_wake_sw = wr_word[0];
        end
        strap_cfg_pkg::GPIO_IN_ADDR, strap_cfg_pkg::STRAP_ADDR: begin
          nxt_bresp = strap_cfg_pkg::RESP_OKAY;
        end
        default: begin
          nxt_bresp = strap_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // read channel: one-cycle registered answer
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = strap_cfg_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        strap_cfg_pkg::GPIO_CTRL_ADDR: nxt_rdata = {24'h000000, gpio_ctrl_ff};
        strap_cfg_pkg::GPIO_OUT_ADDR: nxt_rdata = {24'h000000, gpio_out_ff};
        strap_cfg_pkg::GPIO_IN_ADDR: nxt_rdata = {24'h000000, pin_in_ff};
        strap_cfg_pkg::GEN_CTRL_ADDR: nxt_rdata = gen_ctrl_ff;
        strap_cfg_pkg::STRAP_ADDR: nxt_rdata = {25'h0000000, straps_ff};
        strap_cfg_pkg::WAKE_ADDR: nxt_rdata = {31'h00000000, wake_sw_ff};
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = strap_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // straps: captured on the second clock with link reset released
  always_comb begin
    nxt_straps = straps_ff;
    nxt_sampled = sampled_ff;
    if (!link_reset_n) begin
      nxt_sampled = 1'b0; // R17
      nxt_straps = strap_cfg_pkg::STRAPS_RESET; // R16
    end else if (!sampled_ff && link_rst_d_ff) begin
      nxt_sampled = 1'b1;
      nxt_straps.clock_stop_feature = clock_stop_feature_strap; // R3
      nxt_straps.outside_arbiter = outside_arbiter_strap; // R4
      nxt_straps.bus_speed_66 = bus_speed_strap; // R12
      nxt_straps.ref_clock_125 = ref_clock_source_strap; // R13
      nxt_straps.serial_irq_enable = serial_interrupt_pin; // R14
      nxt_straps.serial_eeprom_enable = pin_in[strap_cfg_pkg::PIN5]; // R8
      nxt_straps.compat_mode = pin_in[strap_cfg_pkg::PIN2]; // R7
    end
  end

  // pin muxing: shared functions take precedence over plain gpio
  logic ovrd_sel;
  assign ovrd_sel =
    gen_ctrl_ff[strap_cfg_pkg::OVRD_HI:strap_cfg_pkg::OVRD_LO]
      == strap_cfg_pkg::OVRD_SEL_A ||
    gen_ctrl_ff[strap_cfg_pkg::OVRD_HI:strap_cfg_pkg::OVRD_LO]
      == strap_cfg_pkg::OVRD_SEL_B; // R6
  always_comb begin
    nxt_pin_out = gpio_out_ff;
    nxt_pin_oe = gpio_ctrl_ff; // R2 R9
    if (straps_ff.clock_stop_feature) begin
      nxt_pin_oe[strap_cfg_pkg::PIN0] = 1'b0; // R5
    end
    if (ovrd_sel) begin
      nxt_pin_oe[strap_cfg_pkg::PIN1] = 1'b1; // R6
      nxt_pin_out[strap_cfg_pkg::PIN1] = power_override_value;
    end
    if (straps_ff.serial_eeprom_enable) begin
      // serial engine owns these pins; gpio drive is withheld
      nxt_pin_oe[strap_cfg_pkg::PIN4] = 1'b0; // R8
      nxt_pin_oe[strap_cfg_pkg::PIN5] = 1'b0;
    end
    nxt_wake_oe = wake_request | wake_sw_ff; // R1
    nxt_clk_stop = straps_ff.clock_stop_feature ?
                   pin_in[strap_cfg_pkg::PIN0] : 1'b1; // R5
    nxt_lock = gen_ctrl_ff[strap_cfg_pkg::LOCK_BIT]; // R11
    nxt_ovrd_out = ovrd_sel & power_override_value; // R6
  end

  always_ff @(posedge clock or posedge global_async_reset) begin
    if (global_async_reset || reset) begin // R10
      gpio_ctrl_ff <= strap_cfg_pkg::GPIO_CTRL_RESET;
      gpio_out_ff <= strap_cfg_pkg::GPIO_OUT_RESET;
      gen_ctrl_ff <= strap_cfg_pkg::GEN_CTRL_RESET;
      wake_sw_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      aw_have_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      w_have_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0000_0000;
      straps_ff <= strap_cfg_pkg::STRAPS_RESET; // R10
      link_rst_d_ff <= 1'b0;
      sampled_ff <= 1'b0;
      pin_out_ff <= 8'h00;
      pin_oe_ff <= 8'h00;
      pin_in_ff <= 8'h00;
      wake_oe_ff <= 1'b0;
      clk_stop_ff <= 1'b1;
      lock_ff <= 1'b0;
      ovrd_out_ff <= 1'b0;
    end else begin
      gpio_ctrl_ff <= nxt_gpio_ctrl;
      gpio_out_ff <= nxt_gpio_out;
      gen_ctrl_ff <= nxt_gen_ctrl;
      wake_sw_ff <= nxt_wake_sw;
      aw_addr_ff <= nxt_aw_addr;
      aw_have_ff <= nxt_aw_have;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      w_have_ff <= nxt_w_have;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      straps_ff <= nxt_straps;
      link_rst_d_ff <= link_reset_n;
      sampled_ff <= nxt_sampled;
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      pin_in_ff <= pin_in;
      wake_oe_ff <= nxt_wake_oe;
      clk_stop_ff <= nxt_clk_stop;
      lock_ff <= nxt_lock;
      ovrd_out_ff <= nxt_ovrd_out;
    end
  end

  // one write and one read in flight; no new beat until the answer drains
  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready = !w_have_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign wake_oe = wake_oe_ff;
  assign clock_stop_request_pin = clk_stop_ff;
  assign lock_mode = lock_ff;
  assign serial_bus_mode = straps_ff.serial_eeprom_enable;
  assign power_override_output = ovrd_out_ff;
  assign straps = straps_ff;
endmodule : bridge_strap_and_gpio_config
`default_nettype wire

// ==== shared/strap_cfg_pkg.sv ====
`default_nettype none
package strap_cfg_pkg;
  // register byte addresses
  localparam logic [7:0] GPIO_CTRL_ADDR = 8'h00;
  localparam logic [7:0] GPIO_OUT_ADDR = 8'h04;
  localparam logic [7:0] GPIO_IN_ADDR = 8'h08;
  localparam logic [7:0] GEN_CTRL_ADDR = 8'h0C;
  localparam logic [7:0] STRAP_ADDR = 8'h10;
  localparam logic [7:0] WAKE_ADDR = 8'h14;
  // field positions
  localparam int LOCK_BIT = 12;
  localparam int OVRD_LO = 20;
  localparam int OVRD_HI = 22;
  localparam logic [2:0] OVRD_SEL_A = 3'h1;
  localparam logic [2:0] OVRD_SEL_B = 3'h3;
  localparam int PIN0 = 0;
  localparam int PIN1 = 1;
  localparam int PIN2 = 2;
  localparam int PIN4 = 4;
  localparam int PIN5 = 5;
  localparam int NUM_PINS = 8;
  // reset values and response codes
  localparam logic [7:0] GPIO_CTRL_RESET = 8'h00;
  localparam logic [7:0] GPIO_OUT_RESET = 8'h00;
  localparam logic [31:0] GEN_CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic clock_stop_feature;
    logic outside_arbiter;
    logic bus_speed_66;
    logic ref_clock_125;
    logic serial_irq_enable;
    logic serial_eeprom_enable;
    logic compat_mode;
  } straps_s;

  localparam straps_s STRAPS_RESET = '{default: 1'b0};
endpackage : strap_cfg_pkg
`default_nettype wire

// ==== sim/strap_cfg_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module strap_cfg_properties (
  input wire logic clock,
  input wire logic reset,
  input wire logic global_async_reset,
  input wire logic link_reset_n,
  input wire logic bus_speed_strap,
  input wire logic ref_clock_source_strap,
  input wire logic wake_request,
  input wire logic wake_oe,
  input wire logic clock_stop_request_pin,
  input wire logic serial_bus_mode,
  input wire logic [7:0] pin_oe,
  input wire strap_cfg_pkg::straps_s straps,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset || global_async_reset);
  AST_WAKE_PULL: assert property (wake_request |=> wake_oe)
    else $error("wake pin not pulled");
  AST_SPEED_CAPTURE: assert property ($rose(link_reset_n) ##1
    link_reset_n [*2] |-> straps.bus_speed_66 == $past(bus_speed_strap))
    else $error("speed strap not captured");
  AST_REF_CAPTURE: assert property ($rose(link_reset_n) ##1
    link_reset_n [*2] |-> straps.ref_clock_125 == $past(ref_clock_source_strap))
    else $error("ref clock strap not captured");
  // six cycles leave room for the capture that follows a reset release
  AST_STRAP_HOLD: assert property (( link_reset_n && !reset) [*6]
    |-> $stable(straps)) else $error("straps moved");
  AST_STRAP_CLEAR: assert property (!link_reset_n [*2] |-> straps == '0)
    else $error("straps kept in link reset");
  AST_GLOBAL_CLEAR: assert property (disable iff (reset)
    global_async_reset |-> straps == '0 && pin_oe == 8'h00 && !wake_oe)
    else $error("global reset left state");
  AST_CLKSTOP_INPUT: assert property (straps.clock_stop_feature [*2]
    |-> !pin_oe[strap_cfg_pkg::PIN0]) else $error("pin0 driven");
  AST_CLKSTOP_IDLE: assert property (!straps.clock_stop_feature [*2]
    |-> clock_stop_request_pin) else $error("clock stop request active");
  AST_SERIAL_RELEASE: assert property (serial_bus_mode [*2]
    |-> pin_oe[5:4] == 2'h0) else $error("serial bus pins driven");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  cover property (straps.serial_eeprom_enable && straps.compat_mode);
  cover property (wake_oe);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : strap_cfg_properties
bind bridge_strap_and_gpio_config strap_cfg_properties u_props (.*);
`default_nettype wire

// ==== sim/upstream_link_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module upstream_link_model (
  input wire logic clock,
  output logic link_reset_n
);
  initial link_reset_n = 1'h0;
  // length of the reset is the caller's choice, prompt or slow
  task automatic hold_reset(input int cycles);
    @(posedge clock);
    link_reset_n <= 1'h0;
    repeat (cycles) @(posedge clock);
    link_reset_n <= 1'h1;
  endtask : hold_reset
endmodule : upstream_link_model
`default_nettype wire

// ==== sim/test_bridge_strap_and_gpio_config.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_bridge_strap_and_gpio_config;
  logic clock, reset, global_async_reset, link_reset_n, wake_request;
  logic power_override_value, clock_stop_feature_strap, outside_arbiter_strap;
  logic bus_speed_strap, ref_clock_source_strap, serial_interrupt_pin;
  logic clock_stop_request_pin, lock_mode, serial_bus_mode, wake_oe;
  logic power_override_output, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_seen;
  logic [3:0] s_axi_wstrb;
  logic [4:0] sv;
  logic [7:0] board, pin_lvl, pin_out, pin_oe, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  strap_cfg_pkg::straps_s straps;
  int n_errors, num_checks;
  // a pin shows the bridge where it drives, else the board level
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & board);
  assign {clock_stop_feature_strap, outside_arbiter_strap, bus_speed_strap,
    ref_clock_source_strap, serial_interrupt_pin} = sv;
  bridge_strap_and_gpio_config u_bridge_strap_and_gpio_config (
    .pin_in(pin_lvl), .*);
  upstream_link_model u_upstream_link_model (.clock(clock),
    .link_reset_n(link_reset_n));
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chk1
  function automatic strap_cfg_pkg::straps_s exp_straps(logic [4:0] s,
    logic [7:0] b);
    return {s, b[strap_cfg_pkg::PIN5], b[strap_cfg_pkg::PIN2]};
  endfunction : exp_straps
  function automatic logic [7:0] exp_oe(logic [7:0] dir,
    strap_cfg_pkg::straps_s s, logic ov);
    exp_oe = dir;
    if (s.clock_stop_feature) exp_oe[0] = 1'h0;
    if (ov) exp_oe[1] = 1'h1;
    if (s.serial_eeprom_enable) exp_oe[5:4] = 2'h0;
  endfunction : exp_oe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge clock);
    {ta, tw} = 2'h0;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(ta && tw)) begin
      @(posedge clock);
      ta |= s_axi_awvalid && s_axi_awready;
      tw |= s_axi_wvalid && s_axi_wready;
      {s_axi_awvalid, s_axi_wvalid} <= {!ta, !tw};
    end
    while (!s_axi_bvalid) @(posedge clock);
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    while (!s_axi_rvalid) @(posedge clock);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    print_verdict();
  end
  initial begin : main
    logic [31:0] d, dir, gc, gout;
    logic [7:0] eo, exp_pins;
    logic [1:0] r;
    logic ov;
    strap_cfg_pkg::straps_s e;
    void'($urandom(32'h198F));
    {reset, global_async_reset, wake_request, power_override_value} = 4'h8;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 49'h0;
    s_axi_wstrb = 4'hF;
    {sv, board} = 13'h00FF;
    repeat (10) @(posedge clock);
    reset <= 1'h0;
    for (int k = 0; k < 8; k++) begin
      @(posedge clock);
      sv <= 5'($urandom);
      board <= 8'($urandom);
      reset <= 1'h1;
      @(posedge clock);
      reset <= 1'h0;
      u_upstream_link_model.hold_reset(k + 2);
      repeat (4) @(posedge clock);
      e = exp_straps(sv, board);
      chk("straps", {25'h0, e}, {25'h0, straps});
      sv <= ~sv;
      rd(strap_cfg_pkg::STRAP_ADDR, d, r);
      chk("strap reg", {25'h0, e}, d);
      gc = {9'h0, 3'(k), 7'h0, k[0], 12'h0};
      ov = gc[22:20] == strap_cfg_pkg::OVRD_SEL_A;
      ov |= gc[22:20] == strap_cfg_pkg::OVRD_SEL_B;
      dir = $urandom;
      wr(strap_cfg_pkg::GPIO_CTRL_ADDR, dir);
      wr(strap_cfg_pkg::GEN_CTRL_ADDR, gc);
      gout = $urandom;
      wr(strap_cfg_pkg::GPIO_OUT_ADDR, gout);
      chk("write resp", 32'(strap_cfg_pkg::RESP_OKAY), 32'(bresp_seen));
      {power_override_value, wake_request} <= {k[1], k[0]};
      repeat (3) @(posedge clock);
      eo = exp_oe(dir[7:0], e, ov);
      exp_pins = gout[7:0];
      if (ov) exp_pins[1] = k[1];
      chk("pin enables", {24'h0, eo}, {24'h0, pin_oe});
      chk("pin values", {24'h0, exp_pins}, {24'h0, pin_out});
      chk1("serial mode", e.serial_eeprom_enable, serial_bus_mode);
      chk1("lock", k[0], lock_mode);
      chk1("override", ov & k[1], power_override_output);
      chk1("wake", k[0], wake_oe);
      chk1("clock stop", e.clock_stop_feature ? board[0] : 1'h1, clock_stop_request_pin);
      rd(strap_cfg_pkg::GPIO_CTRL_ADDR, d, r);
      chk("direction reg", {24'h0, dir[7:0]}, d);
      rd(strap_cfg_pkg::GPIO_IN_ADDR, d, r);
      chk("pin levels", {24'h0, (eo & exp_pins) | (~eo & board)}, d);
    end
    rd(8'h18, d, r);
    chk("unmapped data", 32'h0, d);
    chk("unmapped resp", {30'h0, strap_cfg_pkg::RESP_SLVERR}, {30'h0, r});
    wr(8'h18, 32'h0);
    chk("bad write", 32'(strap_cfg_pkg::RESP_SLVERR), 32'(bresp_seen));
    wake_request <= 1'h0;
    wr(strap_cfg_pkg::WAKE_ADDR, 32'h1);
    repeat (2) @(posedge clock);
    chk1("soft wake", 1'h1, wake_oe);
    // two edges so the checker sees global reset before the run ends
    global_async_reset <= 1'h1;
    repeat (2) @(posedge clock);
    chk1("wake after global", 1'h0, wake_oe);
    chk("straps after global", 32'h0, {25'h0, straps});
    chk("enables after global", 32'h0, {24'h0, pin_oe});
    global_async_reset <= 1'h0;
    print_verdict();
  end
endmodule : test_bridge_strap_and_gpio_config
`default_nettype wire
